/* File: rtl/iad_decoder.sv */
`timescale 1ns/1ns
module iad_decoder #(
    parameter int NPORT = iad_pkg::NPORT
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // inbound memory requests
    input wire iad_pkg::iad_mreq_t mreq,
    output logic mem_valid,
    output iad_pkg::iad_route_t mem_route,
    // outbound i/o requests
    input wire iad_pkg::iad_ioreq_t ioreq,
    output logic io_valid,
    output iad_pkg::iad_route_t io_route,
    output logic [7:0] io_cfg_bus,
    output logic [4:0] io_cfg_dev
);
    // ****************************************
    // register file
    // ****************************************
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [31:0] config_address_reg_r, config_address_reg_nxt;
    logic [11:0] enhanced_cfg_window_base_r, enhanced_cfg_window_base_nxt;
    logic [19:0] top_of_high_memory_r, top_of_high_memory_nxt;
    logic [26:0] ioapic_map_r, ioapic_map_nxt;
    logic [NPORT-1:0][1:0] port_command_reg_r, port_command_reg_nxt;
    logic [NPORT-1:0][31:0] io_win_r, io_win_nxt;
    logic [NPORT-1:0][19:0] pref_base_r, pref_base_nxt;
    logic [NPORT-1:0][19:0] pref_lim_r, pref_lim_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    function automatic logic [7:0] port_off(int p, logic [7:0] sub);
        return 8'(iad_pkg::PORT_BASE + p * iad_pkg::PORT_STRIDE + sub);
    endfunction
    always_comb begin
        ctrl_nxt = ctrl_r;
        config_address_reg_nxt = config_address_reg_r;
        enhanced_cfg_window_base_nxt = enhanced_cfg_window_base_r;
        top_of_high_memory_nxt = top_of_high_memory_r;
        ioapic_map_nxt = ioapic_map_r;
        port_command_reg_nxt = port_command_reg_r;
        io_win_nxt = io_win_r;
        pref_base_nxt = pref_base_r;
        pref_lim_nxt = pref_lim_r;
        if (reg_wr) begin
            case (reg_addr)
                iad_pkg::REG_CTRL: ctrl_nxt = reg_wdata[1:0];
                iad_pkg::REG_CFG_ADDR: config_address_reg_nxt = reg_wdata;
                iad_pkg::REG_ECFG_BASE: begin
                    enhanced_cfg_window_base_nxt = reg_wdata[11:0];
                end
                iad_pkg::REG_TOHM: top_of_high_memory_nxt = reg_wdata[19:0];
                iad_pkg::REG_IOAPIC_MAP: ioapic_map_nxt = reg_wdata[26:0];
                default: ;
            endcase
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr == port_off(p, iad_pkg::PSUB_CTL)) begin
                    port_command_reg_nxt[p] = reg_wdata[1:0];
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_IO_WIN)) begin
                    io_win_nxt[p] = reg_wdata;
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_PREF_BASE)) begin
                    pref_base_nxt[p] = reg_wdata[19:0];
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_PREF_LIM)) begin
                    pref_lim_nxt[p] = reg_wdata[19:0];
                end
            end
        end
    end
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                iad_pkg::REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
                iad_pkg::REG_CFG_ADDR: rdata_nxt = config_address_reg_r;
                iad_pkg::REG_ECFG_BASE: begin
                    rdata_nxt = {20'h0, enhanced_cfg_window_base_r};
                end
                iad_pkg::REG_TOHM: rdata_nxt = {12'h0, top_of_high_memory_r};
                iad_pkg::REG_IOAPIC_MAP: rdata_nxt = {5'h0, ioapic_map_r};
                iad_pkg::REG_STATUS: rdata_nxt = {20'h0, io_route, mem_route};
                default: ;
            endcase
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr == port_off(p, iad_pkg::PSUB_CTL)) begin
                    rdata_nxt = {30'h0, port_command_reg_r[p]};
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_IO_WIN)) begin
                    rdata_nxt = io_win_r[p];
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_PREF_BASE)) begin
                    rdata_nxt = {12'h0, pref_base_r[p]};
                end
                if (reg_addr == port_off(p, iad_pkg::PSUB_PREF_LIM)) begin
                    rdata_nxt = {12'h0, pref_lim_r[p]};
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= iad_pkg::CTRL_RST;
            config_address_reg_r <= iad_pkg::CFG_ADDR_RST;
            enhanced_cfg_window_base_r <= iad_pkg::ECFG_BASE_RST;
            top_of_high_memory_r <= iad_pkg::TOHM_RST;
            ioapic_map_r <= iad_pkg::IOAPIC_RST;
            for (int p = 0; p < NPORT; p++) begin
                port_command_reg_r[p] <= iad_pkg::PCTL_RST;
                io_win_r[p] <= iad_pkg::IO_WIN_RST;
                pref_base_r[p] <= iad_pkg::PREF_BASE_RST;
                pref_lim_r[p] <= iad_pkg::PREF_LIM_RST;
            end
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            config_address_reg_r <= config_address_reg_nxt;
            enhanced_cfg_window_base_r <= enhanced_cfg_window_base_nxt;
            top_of_high_memory_r <= top_of_high_memory_nxt;
            ioapic_map_r <= ioapic_map_nxt;
            port_command_reg_r <= port_command_reg_nxt;
            io_win_r <= io_win_nxt;
            pref_base_r <= pref_base_nxt;
            pref_lim_r <= pref_lim_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata = rdata_r;
    // ****************************************
    // inbound memory decode
    // ****************************************
    function automatic logic in_rng(logic [39:0] a, logic [39:0] lo,
                                    logic [39:0] hi);
        return a >= lo && a <= hi;
    endfunction
    iad_pkg::iad_route_t mem_route_r, mem_route_nxt;
    iad_pkg::iad_route_t mmio_rt;
    logic mem_valid_r;
    logic [2:0] apic_sel;
    logic [39:0] a;
    always_comb begin
        a = mreq.addr;
        mmio_rt = '{tgt: iad_pkg::TGT_HUB, port: 2'h0, coherent: 1'b0};
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (a[39:20] >= pref_base_r[p] && a[39:20] <= pref_lim_r[p]) begin
                mmio_rt.tgt = iad_pkg::TGT_PORT;
                mmio_rt.port = 2'(p);
            end
        end
        apic_sel = ioapic_map_r[int'(a[19:16]) * iad_pkg::IOAPIC_SEL_W +: 3];
        mem_route_nxt = '{iad_pkg::TGT_HUB, 2'h0, 1'b0};
        if (a[39:28] == enhanced_cfg_window_base_r) begin
            if (!ctrl_r[iad_pkg::CTRL_DIS_CFG]) begin
                mem_route_nxt.tgt = iad_pkg::TGT_CFG;
            end else begin
                mem_route_nxt = mmio_rt;
            end
        end else if (in_rng(a, iad_pkg::BRIDGE_LO, iad_pkg::BRIDGE_HI)) begin
            if (a <= iad_pkg::BRIDGE_REG_HI) begin
                mem_route_nxt = mmio_rt;
            end
        end else if (in_rng(a, iad_pkg::IOAPIC_LO, iad_pkg::IOAPIC_HI)) begin
            if (apic_sel != 3'h0 && int'(apic_sel) <= NPORT) begin
                mem_route_nxt.tgt = iad_pkg::TGT_PORT;
                mem_route_nxt.port = 2'(apic_sel - 3'h1);
            end
        end else if (in_rng(a, iad_pkg::TIMER_LO, iad_pkg::TIMER_HI)) begin
            mem_route_nxt.tgt = iad_pkg::TGT_HUB;
        end else if (in_rng(a, iad_pkg::HSMM_LO, iad_pkg::HSMM_HI) ||
                     in_rng(a, iad_pkg::FIRM_LO, iad_pkg::FIRM_HI)) begin
            mem_route_nxt.tgt = iad_pkg::TGT_ABORT;
        end else if (in_rng(a, iad_pkg::INTR_LO, iad_pkg::INTR_HI)) begin
            if (mreq.write) begin
                mem_route_nxt.tgt = iad_pkg::TGT_PROC;
            end
        end else if (a >= iad_pkg::HIGH_MEM_LO &&
                     a[39:20] <= top_of_high_memory_r) begin
            mem_route_nxt.tgt = iad_pkg::TGT_MEM;
            mem_route_nxt.coherent = 1'b1;
        end else begin
            if (mmio_rt.tgt == iad_pkg::TGT_PORT) begin
                mem_route_nxt = mmio_rt;
            end
        end
    end
    // ****************************************
    // outbound i/o decode
    // ****************************************
    iad_pkg::iad_route_t io_rt, io_route_r;
    logic io_valid_r;
    logic [12:0] cfg_bd_r, cfg_bd_nxt;
    logic [NPORT-1:0] vga_en, io_en;
    logic [NPORT-1:0][15:0] io_base, io_lim;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            vga_en[p] = port_command_reg_r[p][iad_pkg::PCTL_VGA];
            io_en[p] = port_command_reg_r[p][iad_pkg::PCTL_IO];
            io_base[p] = io_win_r[p][15:0];
            io_lim[p] = io_win_r[p][31:16];
        end
        cfg_bd_nxt = config_address_reg_r[23:11];
    end
    iad_io_route #(
        .NPORT(NPORT)
    ) u_io_route (
        .ioreq(ioreq),
        .vga_route_enable(vga_en),
        .io_space_access_enable(io_en),
        .io_window_base(io_base),
        .io_window_limit(io_lim),
        .isa_alias_enable(ctrl_r[iad_pkg::CTRL_ISA]),
        .cfg_enable(config_address_reg_r[iad_pkg::CFGA_EN]),
        .route(io_rt)
    );
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_valid_r <= 1'b0;
            mem_route_r <= '{iad_pkg::TGT_HUB, 2'h0, 1'b0};
            io_valid_r <= 1'b0;
            io_route_r <= '{iad_pkg::TGT_HUB, 2'h0, 1'b0};
            cfg_bd_r <= 13'h0000;
        end else begin
            mem_valid_r <= mreq.valid;
            io_valid_r <= ioreq.valid;
            if (mreq.valid) begin
                mem_route_r <= mem_route_nxt;
            end
            if (ioreq.valid) begin
                io_route_r <= io_rt;
                cfg_bd_r <= cfg_bd_nxt;
            end
        end
    end
    assign mem_valid = mem_valid_r;
    assign mem_route = mem_route_r;
    assign io_valid = io_valid_r;
    assign io_route = io_route_r;
    assign io_cfg_bus = cfg_bd_r[12:5];
    assign io_cfg_dev = cfg_bd_r[4:0];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_mreq(logic [39:0] lo, logic [39:0] hi);
        mreq.valid && mreq.addr >= lo && mreq.addr <= hi;
    endsequence
    sequence s_mem_out(iad_pkg::iad_tgt_t t);
        mem_valid && mem_route.tgt == t;
    endsequence
    property p_cfg_accept;
        mreq.valid && mreq.addr[39:28] == enhanced_cfg_window_base_r &&
        !ctrl_r[iad_pkg::CTRL_DIS_CFG] |=> s_mem_out(iad_pkg::TGT_CFG);
    endproperty
    a_cfg_accept: assert property (p_cfg_accept)
        else $error("config window hit not accepted");
    property p_cfg_block;
        mreq.valid && mreq.addr[39:28] == enhanced_cfg_window_base_r &&
        ctrl_r[iad_pkg::CTRL_DIS_CFG] |=> mem_route.tgt != iad_pkg::TGT_CFG;
    endproperty
    a_cfg_block: assert property (p_cfg_block)
        else $error("disabled config window still taken as config");
    property p_bridge_miss;
        s_mreq(iad_pkg::BRIDGE_REG_HI + 40'h1, iad_pkg::BRIDGE_HI) ##0
        mreq.addr[39:28] != enhanced_cfg_window_base_r
        |=> s_mem_out(iad_pkg::TGT_HUB);
    endproperty
    a_bridge_miss: assert property (p_bridge_miss)
        else $error("bridge range miss not sent to hub");
    property p_intr;
        s_mreq(iad_pkg::INTR_LO, iad_pkg::INTR_HI) ##0
        enhanced_cfg_window_base_r != 12'h00f
        |=> mem_route.tgt == ($past(mreq.write) ? iad_pkg::TGT_PROC :
                             iad_pkg::TGT_HUB);
    endproperty
    a_intr: assert property (p_intr)
        else $error("interrupt range misrouted");
    property p_firm;
        s_mreq(iad_pkg::FIRM_LO, iad_pkg::FIRM_HI) ##0
        enhanced_cfg_window_base_r != 12'h00f
        |=> s_mem_out(iad_pkg::TGT_ABORT);
    endproperty
    a_firm: assert property (p_firm)
        else $error("firmware range not aborted");
    property p_high_mem;
        mreq.valid && mreq.addr >= iad_pkg::HIGH_MEM_LO &&
        mreq.addr[39:20] <= top_of_high_memory_r &&
        mreq.addr[39:28] != enhanced_cfg_window_base_r
        |=> s_mem_out(iad_pkg::TGT_MEM) ##0 mem_route.coherent;
    endproperty
    a_high_mem: assert property (p_high_mem)
        else $error("high memory not coherent main memory");
    property p_io_alias;
        ioreq.valid && ioreq.addr[16] |=> io_valid &&
        io_route.tgt == iad_pkg::TGT_HUB;
    endproperty
    a_io_alias: assert property (p_io_alias)
        else $error("bit 16 i/o access not sent to hub");
    property p_io_poweron;
        $fell(srst) ##0 ioreq.valid |=> io_route.tgt == iad_pkg::TGT_HUB;
    endproperty
    a_io_poweron: assert property (p_io_poweron)
        else $error("i/o after reset not sent to hub");
    property p_io_low;
        ioreq.valid && ioreq.addr[15:12] == 4'h0 && ioreq.addr[9:8] != 2'h3
        |=> io_route.tgt != iad_pkg::TGT_PORT;
    endproperty
    a_io_low: assert property (p_io_low)
        else $error("lowest i/o block sent to a port");
endmodule

/* File: rtl/iad_pkg.sv */
package iad_pkg;

    // ****************************************
    // route encoding
    // ****************************************
    typedef enum logic [2:0] {
        TGT_MEM,
        TGT_PORT,
        TGT_HUB,
        TGT_PROC,
        TGT_ABORT,
        TGT_CFG
    } iad_tgt_t;

    typedef struct packed {
        iad_tgt_t tgt;
        logic [1:0] port;
        logic coherent;
    } iad_route_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [39:0] addr;
    } iad_mreq_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [16:3] addr;
        logic [7:0] be;
    } iad_ioreq_t;

    // ****************************************
    // register offsets and fields
    // ****************************************
    localparam int NPORT = 4;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG_ADDR = 8'h04;
    localparam logic [7:0] REG_ECFG_BASE = 8'h08;
    localparam logic [7:0] REG_TOHM = 8'h0c;
    localparam logic [7:0] REG_IOAPIC_MAP = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] PORT_BASE = 8'h20;
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] PSUB_CTL = 8'h00;
    localparam logic [7:0] PSUB_IO_WIN = 8'h04;
    localparam logic [7:0] PSUB_PREF_BASE = 8'h08;
    localparam logic [7:0] PSUB_PREF_LIM = 8'h0c;
    localparam int CTRL_DIS_CFG = 0;
    localparam int CTRL_ISA = 1;
    localparam int PCTL_VGA = 0;
    localparam int PCTL_IO = 1;
    localparam int CFGA_EN = 31;
    localparam int IOAPIC_SEL_W = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [31:0] CFG_ADDR_RST = 32'h0000_0000;
    localparam logic [11:0] ECFG_BASE_RST = 12'hf00;
    localparam logic [19:0] TOHM_RST = 20'h00fff;
    localparam logic [26:0] IOAPIC_RST = 27'h000_0000;
    localparam logic [1:0] PCTL_RST = 2'h0;
    localparam logic [31:0] IO_WIN_RST = 32'h0000_0000;
    localparam logic [19:0] PREF_BASE_RST = 20'hfffff;
    localparam logic [19:0] PREF_LIM_RST = 20'h00000;

    // ****************************************
    // memory map
    // ****************************************
    localparam logic [39:0] BRIDGE_LO = 40'h00_fe00_0000;
    localparam logic [39:0] BRIDGE_HI = 40'h00_febf_ffff;
    localparam logic [39:0] BRIDGE_REG_HI = 40'h00_fe0f_ffff;
    localparam logic [39:0] IOAPIC_LO = 40'h00_fec0_0000;
    localparam logic [39:0] IOAPIC_HI = 40'h00_fec8_ffff;
    localparam logic [39:0] TIMER_LO = 40'h00_fec9_0000;
    localparam logic [39:0] TIMER_HI = 40'h00_fed1_ffff;
    localparam logic [39:0] HSMM_LO = 40'h00_feda_0000;
    localparam logic [39:0] HSMM_HI = 40'h00_fedb_ffff;
    localparam logic [39:0] INTR_LO = 40'h00_fee0_0000;
    localparam logic [39:0] INTR_HI = 40'h00_feef_ffff;
    localparam logic [39:0] FIRM_LO = 40'h00_ff00_0000;
    localparam logic [39:0] FIRM_HI = 40'h00_ffff_ffff;
    localparam logic [39:0] HIGH_MEM_LO = 40'h01_0000_0000;

    // ****************************************
    // i/o map
    // ****************************************
    localparam logic [9:0] VGA_A_LO = 10'h3b0;
    localparam logic [9:0] VGA_A_HI = 10'h3bb;
    localparam logic [9:0] VGA_B_LO = 10'h3c0;
    localparam logic [9:0] VGA_B_HI = 10'h3df;
    localparam logic [15:0] CFG_QWORD = 16'h0cf8;
    localparam logic [7:0] BE_CFG_ADDR = 8'h0f;
    localparam logic [15:0] IO_LOW_BLOCK_HI = 16'h0fff;

endpackage

/* File: rtl/iad_io_route.sv */
`timescale 1ns/1ns
module iad_io_route #(
    parameter int NPORT = iad_pkg::NPORT
) (
    // request
    input wire iad_pkg::iad_ioreq_t ioreq,
    // configuration
    input wire logic [NPORT-1:0] vga_route_enable,
    input wire logic [NPORT-1:0] io_space_access_enable,
    input wire logic [NPORT-1:0][15:0] io_window_base,
    input wire logic [NPORT-1:0][15:0] io_window_limit,
    input wire logic isa_alias_enable,
    input wire logic cfg_enable,
    // result
    output iad_pkg::iad_route_t route
);

    // ****************************************
    // byte span helpers
    // ****************************************
    function automatic logic vga_byte(logic [9:0] a);
        return (a >= iad_pkg::VGA_A_LO && a <= iad_pkg::VGA_A_HI) ||
               (a >= iad_pkg::VGA_B_LO && a <= iad_pkg::VGA_B_HI);
    endfunction

    logic [15:3] qa;
    logic [2:0] lo_byte;
    logic [15:0] start;
    logic vga_all;
    logic cfg_hit;

    always_comb begin
        qa = ioreq.addr[16] ? 13'h0000 : ioreq.addr[15:3];
        lo_byte = 3'h0;
        vga_all = (ioreq.be != 8'h00);
        for (int i = 7; i >= 0; i--) begin
            if (ioreq.be[i]) begin
                lo_byte = 3'(i);
                if (!vga_byte({qa[9:3], 3'(i)})) begin
                    vga_all = 1'b0;
                end
            end
        end
        start = {qa, lo_byte};
        cfg_hit = ({qa, 3'h0} == iad_pkg::CFG_QWORD) &&
                  ((ioreq.be == iad_pkg::BE_CFG_ADDR) ||
                   (cfg_enable && ioreq.be[3:0] == 4'h0 &&
                    ioreq.be[7:4] != 4'h0));
    end

    // ****************************************
    // priority routing
    // ****************************************
    always_comb begin
        route = '{tgt: iad_pkg::TGT_HUB, port: 2'h0, coherent: 1'b0};
        if (vga_all && vga_route_enable != '0) begin
            for (int p = NPORT - 1; p >= 0; p--) begin
                if (vga_route_enable[p]) begin
                    route.port = 2'(p);
                end
            end
            route.tgt = iad_pkg::TGT_PORT;
        end else if (cfg_hit) begin
            route.tgt = iad_pkg::TGT_CFG;
        end else if (isa_alias_enable && start[9:8] != 2'h0) begin
            route.tgt = iad_pkg::TGT_HUB;
        end else if (start > iad_pkg::IO_LOW_BLOCK_HI) begin
            for (int p = NPORT - 1; p >= 0; p--) begin
                if (io_space_access_enable[p] &&
                    start >= io_window_base[p] &&
                    start <= io_window_limit[p]) begin
                    route.tgt = iad_pkg::TGT_PORT;
                    route.port = 2'(p);
                end
            end
        end
    end

endmodule

/* File: dv/iad_far_model.sv */
`timescale 1ns/1ns
// ****************************************
// far side: counts routed deliveries
// ****************************************
module iad_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // routed results
    input wire logic mem_valid,
    input wire logic io_valid,
    // tally
    output int delivered
);
    always_ff @(posedge clk) begin
        if (srst) begin
            delivered <= 0;
        end else begin
            delivered <= delivered + int'(mem_valid) + int'(io_valid);
        end
    end
endmodule

/* File: dv/test_iad_decoder.sv */
`timescale 1ns/1ns
module test_iad_decoder;
    localparam logic [2:0] M = iad_pkg::TGT_MEM;
    localparam logic [2:0] P = iad_pkg::TGT_PORT;
    localparam logic [2:0] H = iad_pkg::TGT_HUB;
    localparam logic [2:0] R = iad_pkg::TGT_PROC;
    localparam logic [2:0] A = iad_pkg::TGT_ABORT;
    localparam logic [2:0] C = iad_pkg::TGT_CFG;
    logic clk, srst, reg_wr, reg_rd, mem_valid, io_valid;
    logic [7:0] reg_addr, io_cfg_bus;
    logic [31:0] reg_wdata, reg_rdata;
    logic [4:0] io_cfg_dev;
    iad_pkg::iad_mreq_t mreq;
    iad_pkg::iad_ioreq_t ioreq;
    iad_pkg::iad_route_t mem_route, io_route;
    logic [5:0] mq[$], iq[$];
    int mismatches = 0, total_checks = 0, n_req = 0, delivered;
    iad_decoder iad_decoder_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mreq(mreq), .mem_valid(mem_valid),
        .mem_route(mem_route), .ioreq(ioreq), .io_valid(io_valid),
        .io_route(io_route), .io_cfg_bus(io_cfg_bus),
        .io_cfg_dev(io_cfg_dev));
    iad_far_model iad_far_model_i (.clk(clk), .srst(srst),
        .mem_valid(mem_valid), .io_valid(io_valid), .delivered(delivered));
    function automatic logic [5:0] key(iad_pkg::iad_route_t r);
        return {r.tgt, (r.tgt == P) ? r.port : 2'h0, r.coherent};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    task automatic mr(logic w, logic [39:0] a, logic [2:0] t, logic [1:0] p);
        @(posedge clk);
        mreq <= '{1'b1, w, a}; n_req++;
        mq.push_back({t, (t == P) ? p : 2'h0, t == M});
        @(posedge clk);
        mreq.valid <= 1'b0;
    endtask
    task automatic io(logic [16:0] a, logic [7:0] be, logic [2:0] t,
                      logic [1:0] p);
        @(posedge clk);
        ioreq <= '{1'b1, 1'b0, a[16:3], be}; n_req++;
        iq.push_back({t, (t == P) ? p : 2'h0, 1'b0});
        @(posedge clk);
        ioreq.valid <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (mem_valid === 1'b1) begin
            chk("mem_route", key(mem_route), mq.pop_front());
        end
        if (io_valid === 1'b1) begin
            chk("io_route", key(io_route), iq.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(3000 * 40);
        mismatches++;
        report_and_stop();
    end
    initial begin
        srst = 1'b1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        mreq = '0; ioreq = '0;
        void'($urandom(83));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        n_req++;
        ioreq <= '{1'b1, 1'b0, 14'h0200, 8'h01};
        iq.push_back({H, 2'h0, 1'b0});
        @(posedge clk);
        ioreq.valid <= 1'b0;
        wr(8'h0c, 32'h1fff); wr(8'h38, 32'h2000); wr(8'h3c, 32'h2fff);
        wr(8'h20, 32'h2); wr(8'h24, 32'h17ff_0800);
        wr(8'h40, 32'h1);
        wr(8'h04, 32'h8012_3800); wr(8'h10, 32'h3);
        rd(8'h0c, 32'h1fff); rd(8'hfc, 32'h0);
        mr(0, 40'h01_0000_0000, M, 0); mr(1, 40'h01_ffff_ffff, M, 0);
        mr(0, 40'h02_0000_0040, P, 1);
        mr(0, 40'h03_0000_0000, H, 0);
        mr(1, 40'h00_fee0_0000, R, 0); mr(0, 40'h00_fee0_0000, H, 0);
        mr(0, 40'h00_feda_0000, A, 0); mr(0, 40'h00_ff00_0000, A, 0);
        mr(0, 40'h00_fec9_0000, H, 0);
        mr(0, 40'h00_fe10_0000, H, 0);
        mr(0, 40'hf0_0000_0000, C, 0);
        mr(0, 40'h00_fe00_0000, H, 0);
        mr(0, 40'h00_fec0_0000, P, 2);
        repeat (4) mr(0, {8'h01, $urandom()}, M, 0);
        wr(8'h00, 32'h1);
        mr(0, 40'hf0_0000_0000, H, 0);
        $display("memory decode test done");
        io(17'h00cf8, 8'h0f, C, 0); io(17'h00cf8, 8'hf0, C, 0);
        #1 chk("io_cfg_bus", 32'(io_cfg_bus), 32'h12);
        chk("io_cfg_dev", 32'(io_cfg_dev), 32'h07);
        io(17'h003b8, 8'h0f, P, 2); io(17'h007b8, 8'h0f, P, 2);
        io(17'h003b8, 8'h1f, H, 0); io(17'h01000, 8'h01, P, 0);
        io(17'h00800, 8'h01, H, 0); io(17'h01800, 8'h01, H, 0);
        io(17'h11000, 8'h01, H, 0);
        wr(8'h00, 32'h3);
        io(17'h01100, 8'h01, H, 0); io(17'h01000, 8'h01, P, 0);
        io(17'h003b0, 8'h01, P, 2);
        repeat (4) @(posedge clk);
        chk("delivered", 32'(delivered), 32'(n_req));
        $display("i/o decode test done");
        report_and_stop();
    end
endmodule
